// File: verilog/ifs_pkg.sv
// Package for the I2C FIFO raw status flag block.
package ifs_pkg;

    // ------------------------------------------------------------------
    // FIFO geometry
    // ------------------------------------------------------------------
    localparam int FIFO_DEPTH = 16;
    localparam int CNT_W = 5;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TX_THRESH = 8'h04;
    localparam logic [7:0] ADDR_RX_THRESH = 8'h08;
    localparam logic [7:0] ADDR_TX_DATA = 8'h0C;
    localparam logic [7:0] ADDR_RX_DATA = 8'h10;
    localparam logic [7:0] ADDR_MASK = 8'h14;
    localparam logic [7:0] ADDR_RAW_STATUS = 8'h18;
    localparam logic [7:0] ADDR_MASKED_STATUS = 8'h1C;
    localparam logic [7:0] ADDR_CLEAR = 8'h20;
    localparam logic [7:0] ADDR_LEVELS = 8'h24;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_TX_EMPTY = 0;
    localparam int BIT_TX_LOW = 1;
    localparam int BIT_TX_FULL = 2;
    localparam int BIT_TX_OVERRUN = 3;
    localparam int BIT_RX_EMPTY = 4;
    localparam int BIT_RX_HIGH = 5;
    localparam int BIT_RX_FULL = 6;
    localparam int FLAG_W = 7;
    localparam int BIT_CTRL_FLUSH_TX = 0;
    localparam int BIT_CTRL_FLUSH_RX = 1;
    localparam int LEVEL_RX_POS = 8;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [6:0] RESET_FLAGS = 7'h13;
    localparam logic [6:0] RESET_MASK = 7'h00;
    localparam logic [CNT_W-1:0] RESET_TX_THRESH = 5'h00;
    localparam logic [CNT_W-1:0] RESET_RX_THRESH = 5'h10;

    // Register-port request carried as one bundle.
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ifs_req_s;

endpackage

// File: verilog/ifs_fifo.sv
// Flip-flop FIFO with an entry count, used for transmit and receive.
`timescale 1ns/1ps
module ifs_fifo
    import ifs_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic push,
    input wire logic [DATA_W-1:0] push_data,
    input wire logic pop,
    output logic [DATA_W-1:0] pop_data,
    output logic [CNT_W-1:0] count
);

    logic [DATA_W-1:0] mem [FIFO_DEPTH];
    logic [CNT_W-2:0] wr_ptr;
    logic [CNT_W-2:0] rd_ptr;
    logic do_push;
    logic do_pop;

    // A push into a full FIFO is dropped; the word is lost.
    assign do_push = push && (count != CNT_W'(FIFO_DEPTH));
    assign do_pop = pop && (count != '0);
    assign pop_data = mem[rd_ptr];

    always_ff @(posedge mclk) begin
        if (do_push) begin
            mem[wr_ptr] <= push_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n || flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            case ({do_push, do_pop})
                2'b10: count <= count + 1'b1;
                2'b01: count <= count - 1'b1;
                default: count <= count;
            endcase
        end
    end

endmodule // ifs_fifo

// File: verilog/ifs_flags.sv
// Raw and masked FIFO status flags of the I2C controller, with registers.
// How it works
// (RULE1) Transmit-empty, bit 0, resets to one, tracks an empty transmit FIFO.
// (RULE2) Transmit-low, bit 1, resets one, set while count at or below threshold.
// (RULE3) Transmit-full, bit 2, resets zero, set only while transmit FIFO full.
// (RULE4) Transmit-overrun, bit 3, resets zero, set by a write to full FIFO.
// (RULE5) Transmit-overrun is sticky until software writes one to clear register.
// (RULE6) Software never writes into a full transmit FIFO.
// (RULE7) After an overrun software flushes the transmitter with the flush bit.
// (RULE8) Receive-empty, bit 4, resets to one, tracks an empty receive FIFO.
// (RULE9) Receive-high, bit 5, set while receive count at or above threshold.
// (RULE10) Receive-full, bit 6, resets zero, set while receive FIFO is full.
// (RULE11) A flag raises the interrupt only when its mask bit is one.
// (RULE12) Raw status bits 15 to 7 read zero; writes to it do nothing.
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
module ifs_flags
    import ifs_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    input wire logic eng_rx_push,
    input wire logic [DATA_W-1:0] eng_rx_data,
    input wire logic eng_tx_pop,
    output logic [DATA_W-1:0] eng_tx_data,
    output logic [CNT_W-1:0] tx_count,
    output logic irq
);

    // ------------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------------
    ifs_req_s req;
    assign req = '{addr: addr, wdata: wdata, wr: wr_en, rd: rd_en};

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    logic wr_ctrl;
    logic wr_txd;
    logic rd_rxd;
    logic wr_clr;
    assign wr_ctrl = req.wr && hit(req.addr, ADDR_CTRL);
    assign wr_txd = req.wr && hit(req.addr, ADDR_TX_DATA);
    assign rd_rxd = req.rd && hit(req.addr, ADDR_RX_DATA);
    assign wr_clr = req.wr && hit(req.addr, ADDR_CLEAR);

    // ------------------------------------------------------------------
    // Control, thresholds and mask
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] tx_thresh;
    logic [CNT_W-1:0] rx_thresh;
    logic [FLAG_W-1:0] mask;
    logic flush_tx;
    logic flush_rx;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tx_thresh <= RESET_TX_THRESH;
            rx_thresh <= RESET_RX_THRESH;
            mask <= RESET_MASK;
        end else if (req.wr) begin
            if (hit(req.addr, ADDR_TX_THRESH)) begin
                tx_thresh <= req.wdata[CNT_W-1:0];
            end else if (hit(req.addr, ADDR_RX_THRESH)) begin
                rx_thresh <= req.wdata[CNT_W-1:0];
            end else if (hit(req.addr, ADDR_MASK)) begin
                mask <= req.wdata[FLAG_W-1:0];
            end
        end
    end

    // Flush bits self-clear: each write of one is a single-cycle flush.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flush_tx <= 1'b0;
            flush_rx <= 1'b0;
        end else begin
            flush_tx <= wr_ctrl && req.wdata[BIT_CTRL_FLUSH_TX];
            flush_rx <= wr_ctrl && req.wdata[BIT_CTRL_FLUSH_RX];
        end
    end

    // ------------------------------------------------------------------
    // FIFOs
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] rx_count;
    logic [DATA_W-1:0] rx_head;

    // Software is expected to avoid writing a full transmit FIFO. (RULE6)
    ifs_fifo u_tx_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .flush(flush_tx),
        .push(wr_txd),
        .push_data(req.wdata[DATA_W-1:0]),
        .pop(eng_tx_pop),
        .pop_data(eng_tx_data),
        .count(tx_count)
    );

    ifs_fifo u_rx_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .flush(flush_rx),
        .push(eng_rx_push),
        .push_data(eng_rx_data),
        .pop(rd_rxd),
        .pop_data(rx_head),
        .count(rx_count)
    );

    // ------------------------------------------------------------------
    // Raw flags
    // ------------------------------------------------------------------
    logic [FLAG_W-1:0] raw;
    logic [FLAG_W-1:0] level;
    logic tx_overrun;
    logic tx_full_now;

    assign tx_full_now = tx_count == CNT_W'(FIFO_DEPTH);

    // Level flags are registered from the counts so they lag by one cycle
    // and read as clean flip-flop outputs.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            level[BIT_TX_EMPTY] <= RESET_FLAGS[BIT_TX_EMPTY];
            level[BIT_TX_LOW] <= RESET_FLAGS[BIT_TX_LOW];
            level[BIT_TX_FULL] <= RESET_FLAGS[BIT_TX_FULL];
            level[BIT_TX_OVERRUN] <= 1'b0;
            level[BIT_RX_EMPTY] <= RESET_FLAGS[BIT_RX_EMPTY];
            level[BIT_RX_HIGH] <= RESET_FLAGS[BIT_RX_HIGH];
            level[BIT_RX_FULL] <= RESET_FLAGS[BIT_RX_FULL];
        end else begin
            level[BIT_TX_EMPTY] <= tx_count == '0; // RULE1
            level[BIT_TX_LOW] <= tx_count <= tx_thresh; // RULE2
            level[BIT_TX_FULL] <= tx_full_now; // RULE3
            level[BIT_TX_OVERRUN] <= 1'b0;
            level[BIT_RX_EMPTY] <= rx_count == '0; // RULE8
            level[BIT_RX_HIGH] <= rx_count >= rx_thresh; // RULE9
            level[BIT_RX_FULL] <= rx_count == CNT_W'(FIFO_DEPTH); // RULE10
        end
    end

    // Overrun is sticky; a new overrun beats a clear in the same cycle.
    // A flush does not clear it, so software sees it until acknowledged.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tx_overrun <= RESET_FLAGS[BIT_TX_OVERRUN];
        end else if (wr_txd && tx_full_now) begin
            tx_overrun <= 1'b1; // RULE4
        end else if (wr_clr && req.wdata[BIT_TX_OVERRUN]) begin
            tx_overrun <= 1'b0; // RULE5
        end
    end

    // Each flag has one owning process; the sticky bit is merged here.
    always_comb begin
        raw = level;
        raw[BIT_TX_OVERRUN] = tx_overrun;
    end

    // The flush that software issues after an overrun empties the FIFO. (RULE7)

    // ------------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------------
    logic [FLAG_W-1:0] masked;
    assign masked = raw & mask; // RULE11
    assign irq = |masked; // RULE11

    // ------------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ------------------------------------------------------------------
    logic [31:0] next_rdata;

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hit(req.addr, ADDR_CTRL)) begin
            next_rdata = 32'h0000_0000;
        end else if (hit(req.addr, ADDR_TX_THRESH)) begin
            next_rdata = 32'(tx_thresh);
        end else if (hit(req.addr, ADDR_RX_THRESH)) begin
            next_rdata = 32'(rx_thresh);
        end else if (hit(req.addr, ADDR_RX_DATA)) begin
            next_rdata = 32'(rx_head);
        end else if (hit(req.addr, ADDR_MASK)) begin
            next_rdata = 32'(mask);
        end else if (hit(req.addr, ADDR_RAW_STATUS)) begin
            next_rdata = 32'(raw); // RULE12
        end else if (hit(req.addr, ADDR_MASKED_STATUS)) begin
            next_rdata = 32'(masked);
        end else if (hit(req.addr, ADDR_LEVELS)) begin
            next_rdata = 32'(tx_count) | (32'(rx_count) << LEVEL_RX_POS);
        end
    end

    // Data stand only in the cycle after the read strobe.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata <= 32'h0000_0000;
        end else if (req.rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

endmodule // ifs_flags

// File: tb/ifs_flags_properties.sv
// Checker for the FIFO status flag block.
`timescale 1ns/1ps
module ifs_flags_chk
    import ifs_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [31:0] rdata,
    input wire logic eng_tx_pop,
    input wire logic [CNT_W-1:0] tx_count,
    input wire logic irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [CNT_W-1:0] tx_prev;
    logic [1:0] stab;
    logic [6:0] mask_m;
    logic raw_q;
    logic fl_q;
    logic tx_wr;
    assign tx_wr = wr_en && addr == ADDR_TX_DATA;
    // Flags lag the count, so they are judged only once it has settled.
    always_ff @(posedge mclk) begin
        tx_prev <= tx_count;
        raw_q <= rd_en && addr == ADDR_RAW_STATUS;
        fl_q <= wr_en && addr == ADDR_CTRL && wdata[BIT_CTRL_FLUSH_TX];
        if (!rst_n || tx_count != tx_prev) begin
            stab <= 2'h0;
        end else if (stab != 2'h3) begin
            stab <= stab + 2'h1;
        end
        if (!rst_n) begin
            mask_m <= RESET_MASK;
        end else if (wr_en && addr == ADDR_MASK) begin
            mask_m <= wdata[6:0];
        end
    end
    chk_reset_state: assert property (
        $rose(rst_n) |-> tx_count == 5'h00 && !irq)
        else $error("Count or interrupt not cleared by reset.");
    chk_tx_empty: assert property (
        raw_q && stab == 2'h3 |-> rdata[0] == (tx_prev == 5'h00))
        else $error("Transmit empty flag wrong.");
    chk_tx_full: assert property (
        raw_q && stab == 2'h3 |-> rdata[2] == (tx_prev == 5'h10))
        else $error("Transmit full flag wrong.");
    chk_raw_reserved: assert property (
        raw_q |-> rdata[31:7] == 25'h0)
        else $error("Reserved status bits not zero.");
    chk_push_count: assert property (
        tx_wr && tx_count < 5'h10 && !eng_tx_pop && !fl_q
        |=> tx_count == $past(tx_count) + 5'h01)
        else $error("Transmit write not counted.");
    chk_full_drop: assert property (
        tx_wr && tx_count == 5'h10 && !eng_tx_pop && !fl_q |=> tx_count == 5'h10)
        else $error("Write to full FIFO changed the count.");
    chk_pop_count: assert property (
        eng_tx_pop && tx_count != 5'h00 && !wr_en && !fl_q
        |=> tx_count == $past(tx_count) - 5'h01)
        else $error("Transmit pop not counted.");
    chk_count_bound: assert property (
        tx_count <= 5'h10)
        else $error("Transmit count above depth.");
    chk_irq_masked: assert property (
        mask_m == 7'h00 |-> !irq)
        else $error("Interrupt raised with all flags masked.");
    cover property (tx_wr && tx_count == 5'h10);
    cover property (irq);
    cover property (eng_tx_pop && tx_count != 5'h00);
endmodule // ifs_flags_chk

bind ifs_flags ifs_flags_chk chk (.mclk(mclk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .eng_tx_pop(eng_tx_pop), .tx_count(tx_count), .irq(irq));

// File: tb/ifs_eng_model.sv
// Serial engine model that fills the receive FIFO and drains the transmit one.
`timescale 1ns/1ps
module ifs_eng_model
    import ifs_pkg::*;
(
    output logic push,
    output logic [DATA_W-1:0] data,
    output logic pop,
    input wire logic mclk
);
    initial begin
        push = 1'b0;
        pop = 1'b0;
        data = 8'h00;
    end
    // The byte lane shows the inverse after a push so nothing relies on a hold.
    task automatic send(input logic [DATA_W-1:0] b);
        @(posedge mclk);
        push <= 1'b1;
        data <= b;
        @(posedge mclk);
        push <= 1'b0;
        data <= ~b;
    endtask
    task automatic take();
        @(posedge mclk);
        pop <= 1'b1;
        @(posedge mclk);
        pop <= 1'b0;
    endtask
endmodule // ifs_eng_model

// File: tb/testbench.sv
// Self-checking testbench for the FIFO status flag block.
`timescale 1ns/1ps
module testbench
    import ifs_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [31:0] rdata;
    logic [31:0] d;
    logic eng_rx_push;
    logic eng_tx_pop;
    logic [DATA_W-1:0] eng_rx_data;
    logic [DATA_W-1:0] eng_tx_data;
    logic [CNT_W-1:0] tx_count;
    logic irq;
    int failures = 0;
    int n_compared = 0;
    int cyc = 0;
    ifs_flags uut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .eng_rx_push(eng_rx_push), .eng_rx_data(eng_rx_data),
        .eng_tx_pop(eng_tx_pop), .eng_tx_data(eng_tx_data),
        .tx_count(tx_count), .irq(irq));
    ifs_eng_model eng (.push(eng_rx_push), .data(eng_rx_data),
        .pop(eng_tx_pop), .mclk(mclk));
    initial begin
        forever #5 mclk = ~mclk;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1;
        v = rdata;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic raw(input logic [31:0] exp);
        repeat (3) @(posedge mclk);
        rd(ADDR_RAW_STATUS, d);
        cmp(d, exp);
    endtask
    task automatic irqc(input logic exp);
        @(posedge mclk);
        #1;
        cmp({31'h0, irq}, {31'h0, exp});
    endtask
    task automatic stop_test();
        $display("compared=%0d failures=%0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Far more than the sequence needs; a hang is cut short here.
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            stop_test();
        end
    end
    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        raw(32'h13);
        rd(ADDR_MASK, d);
        cmp(d, 32'h0);
        wr(ADDR_RAW_STATUS, 32'hFFFFFFFF);
        raw(32'h13);
        rd(8'hFC, d);
        cmp(d, 32'h0);
        wr(ADDR_MASK, 32'h1);
        irqc(1'b1);
        wr(ADDR_MASK, 32'h0);
        irqc(1'b0);
        wr(ADDR_TX_THRESH, 32'h2);
        rd(ADDR_TX_THRESH, d);
        cmp(d, 32'h2);
        for (int i = 0; i < 2; i++) wr(ADDR_TX_DATA, 32'hA0 + i);
        raw(32'h12);
        wr(ADDR_TX_DATA, 32'hA2);
        raw(32'h10);
        for (int i = 3; i < 16; i++) wr(ADDR_TX_DATA, 32'hA0 + i);
        raw(32'h14);
        // Deliberate write into the full FIFO to provoke the overrun.
        wr(ADDR_TX_DATA, 32'hEE);
        raw(32'h1C);
        cmp({27'h0, tx_count}, 32'h10);
        cmp({24'h0, eng_tx_data}, 32'hA0);
        wr(ADDR_MASK, 32'h8);
        irqc(1'b1);
        rd(ADDR_MASKED_STATUS, d);
        cmp(d, 32'h8);
        eng.take();
        raw(32'h18);
        wr(ADDR_CLEAR, 32'h8);
        raw(32'h10);
        irqc(1'b0);
        wr(ADDR_CTRL, 32'h1);
        raw(32'h13);
        wr(ADDR_RX_THRESH, 32'h3);
        rd(ADDR_RX_THRESH, d);
        cmp(d, 32'h3);
        eng.send(8'h50);
        raw(32'h03);
        for (int i = 1; i < 3; i++) eng.send(8'(8'h50 + i));
        raw(32'h23);
        for (int i = 3; i < 16; i++) eng.send(8'(8'h50 + i));
        raw(32'h63);
        rd(ADDR_RX_DATA, d);
        cmp(d, 32'h50);
        raw(32'h23);
        for (int i = 0; i < 13; i++) rd(ADDR_RX_DATA, d);
        raw(32'h03);
        rd(ADDR_LEVELS, d);
        cmp(d, 32'h200);
        wr(ADDR_CTRL, 32'h2);
        raw(32'h13);
        // Unpaced fill of exactly the depth from empty, no status polled: no overrun may appear.
        for (int i = 0; i < 16; i++) wr(ADDR_TX_DATA, 32'(i));
        raw(32'h14);
        stop_test();
    end
endmodule // testbench
